// ---- logic/gpb_regs.svh ----
// register offsets, reset values and timing counts of the pin port
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH
`define GPB_LB_BASE 32'h6000_0000
`define GPB_OFS_ORIENT 8'h00
`define GPB_OFS_ORIENT_CLR 8'h04
`define GPB_OFS_ORIENT_SET 8'h08
`define GPB_OFS_ORIENT_FLIP 8'h0C
`define GPB_OFS_DRIVE 8'h10
`define GPB_OFS_DRIVE_CLR 8'h14
`define GPB_OFS_DRIVE_SET 8'h18
`define GPB_OFS_DRIVE_FLIP 8'h1C
`define GPB_OFS_INVAL 8'h20
`define GPB_RST_ORIENT 32'h0000_0000
`define GPB_RST_DRIVE 32'h0000_0000
`define GPB_SYNC_CYC 2
`define GPB_GRP_W 8
`endif

// ---- logic/gpb_pkg.sv ----
// shared types of the pin port
`default_nettype none
package gpb_pkg;
  typedef enum logic [1:0] {GPB_WR, GPB_CLR, GPB_SET, GPB_TGL} gpb_op_t;
  typedef enum logic [1:0] {GPB_IDLE, GPB_SYNC, GPB_EXEC, GPB_DONE} gpb_apb_st_t;
  typedef struct packed {
    logic hit;
    logic drv;
    logic inp;
    gpb_op_t op;
  } gpb_dec_t;
endpackage
`default_nettype wire

// ---- logic/gpb_sync_if.sv ----
// link between the port core and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface gpb_sync_if #(parameter int W = 32, parameter int G = 4);
  logic [G-1:0] grp_en;
  logic [W-1:0] in_val;
  logic [W-1:0] pad_lvl;
  modport ctl (output grp_en, input in_val, input pad_lvl);
  modport smp (input grp_en, output in_val, output pad_lvl);
endinterface
`default_nettype wire

// ---- logic/gpb_sync.sv ----
// input synchroniser with per-group sampling enable
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"
module gpb_sync #(
  parameter int W = 32,
  parameter int G = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic port_off,
  input wire logic [W-1:0] pad_in,
  gpb_sync_if.smp sif
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] val;
  } gpb_sync_t;
  gpb_sync_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pad_in;
    s_nxt.s2 = s_r.s1;
    for (int g = 0; g < G; g++) begin
      if (sif.grp_en[g]) begin
        s_nxt.val[g*`GPB_GRP_W +: `GPB_GRP_W] = s_r.s2[g*`GPB_GRP_W +: `GPB_GRP_W];
      end
    end
    if (!nrst || port_off) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_nxt_q: s_r <= s_nxt;
  end

  assign sif.in_val = s_r.val;
  assign sif.pad_lvl = s_r.s2;

  a_sync_hold: assert property (@(posedge clk) disable iff (!nrst)
    (sif.grp_en == '0 && !port_off) |=> $stable(sif.in_val))
    else $error("input value changed while sampling was off");
  a_sync_cont: assert property (@(posedge clk) disable iff (!nrst)
    (&sif.grp_en && !port_off) |=> sif.in_val == $past(s_r.s2))
    else $error("enabled sampling did not take the synchronised level");
endmodule // gpb_sync
`default_nettype wire

// ---- logic/gpb_pad.sv ----
// pad drive, input buffer and pull control with retention
`timescale 1ns/1ps
`default_nettype none
module gpb_pad #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic port_off,
  input wire logic [W-1:0] orient,
  input wire logic [W-1:0] drive,
  input wire logic [W-1:0] in_en,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] pmux_en,
  input wire logic [W-1:0] analog_sel,
  input wire logic [W-1:0] periph_drive,
  input wire logic [W-1:0] periph_oe,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe_n,
  output logic [W-1:0] pad_ie,
  output logic [W-1:0] pad_pull
);
  typedef struct packed {
    logic [W-1:0] out;
    logic [W-1:0] oe_n;
    logic [W-1:0] ie;
    logic [W-1:0] pull;
  } gpb_pad_t;
  gpb_pad_t s_r, s_nxt;
  logic [W-1:0] drv_en;

  assign drv_en = ((pmux_en & periph_oe) | (~pmux_en & orient)) & ~analog_sel;

  always_comb begin
    s_nxt = s_r;
    if (!port_off) begin
      // per pin: muxed pins take the peripheral level
      s_nxt.out = (pmux_en & periph_drive) | (~pmux_en & drive);
      s_nxt.oe_n = ~drv_en;
      s_nxt.ie = (in_en | pmux_en) & ~analog_sel;
      s_nxt.pull = pull_en & ~drv_en & ~analog_sel;
    end
    if (!nrst) begin
      s_nxt.out = '0;
      s_nxt.oe_n = '1;
      s_nxt.ie = '0;
      s_nxt.pull = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign pad_out = s_r.out;
  assign pad_oe_n = s_r.oe_n;
  assign pad_ie = s_r.ie;
  assign pad_pull = s_r.pull;

  a_rst_input: assert property (@(posedge clk)
    !nrst |=> (pad_oe_n == '1 && pad_ie == '0 && pad_pull == '0))
    else $error("pad not fully disabled in reset");
  a_analog_off: assert property (@(posedge clk) disable iff (!nrst)
    !port_off |=> ((pad_ie | pad_pull | ~pad_oe_n) & $past(analog_sel)) == '0)
    else $error("digital feature left on for analog pin");
  a_dir_drive: assert property (@(posedge clk) disable iff (!nrst)
    (!port_off && pmux_en == '0 && analog_sel == '0)
    |=> (pad_oe_n == ~$past(orient) && pad_out == $past(drive)))
    else $error("pad drive does not follow orient and drive level");
endmodule // gpb_pad
`default_nettype wire

// ---- logic/gpb_port.sv ----
// pin port core: local bus and apb register access, sampling, pads
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"

// Function
// - pins grouped, up to 32 per port
// - one write sets, clears, flips selected pins
// - orient, drive, input reachable from both buses
// - reset leaves every pin fully disabled input
// - power-down keeps pads, loses registers, synchronisers
// - keeps working in sleep while clocked
// - main clock; apb rate derived from it
// - local bus access served first
// - apb access waits out local bus access
// - input synchronisers run on main clock
// - debug halt freezes nothing
// - protected register ignores cpu writes
// - debug halt lifts all write protection
// - debugger accesses never write protected
// - analog selection disables pad digital features
// - local bus never waits
// - local bus takes byte, half, word
// - local bus base, same register map
// - local bus: orient/drive full ops, input read
// - muxed peripheral drives pad, reads level
// - on-demand sampling delays read two cycles
// - sampling enable per eight pins
// - set, clear, flip masks; zeros unchanged
// - orient one drives, zero is input
module gpb_port #(
  parameter int W = 32,
  parameter int G = 4,
  parameter logic [31:0] LB_BASE = `GPB_LB_BASE
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic port_off,
  input wire logic dbg_halt,
  input wire logic lb_valid,
  input wire logic lb_write,
  input wire logic [31:0] lb_addr,
  input wire logic [1:0] lb_size,
  input wire logic [31:0] lb_wdata,
  output logic [31:0] lb_rdata,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pdbg,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [7:0] wprot,
  input wire logic [G-1:0] continuous_sync_group,
  input wire logic [W-1:0] in_en,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] pmux_en,
  input wire logic [W-1:0] analog_sel,
  input wire logic [W-1:0] periph_drive,
  input wire logic [W-1:0] periph_oe,
  output logic [W-1:0] periph_level,
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe_n,
  output logic [W-1:0] pad_ie,
  output logic [W-1:0] pad_pull
);
  import gpb_pkg::*;

  typedef struct packed {
    logic [W-1:0] orient;
    logic [W-1:0] drive;
    gpb_apb_st_t st;
    logic [1:0] cnt;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [31:0] lb_rdata;
    logic [W-1:0] periph_level;
  } gpb_top_t;
  gpb_top_t s_r, s_nxt;

  gpb_sync_if #(.W(W), .G(G)) sif ();

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic gpb_dec_t decode(input logic [7:0] ofs);
    gpb_dec_t d;
    d = '{hit: 1'b1, drv: 1'b0, inp: 1'b0, op: GPB_WR};
    case (ofs)
      `GPB_OFS_ORIENT: d.op = GPB_WR;
      `GPB_OFS_ORIENT_CLR: d.op = GPB_CLR;
      `GPB_OFS_ORIENT_SET: d.op = GPB_SET;
      `GPB_OFS_ORIENT_FLIP: d.op = GPB_TGL;
      `GPB_OFS_DRIVE: d.drv = 1'b1;
      `GPB_OFS_DRIVE_CLR: begin
        d.drv = 1'b1;
        d.op = GPB_CLR;
      end
      `GPB_OFS_DRIVE_SET: begin
        d.drv = 1'b1;
        d.op = GPB_SET;
      end
      `GPB_OFS_DRIVE_FLIP: begin
        d.drv = 1'b1;
        d.op = GPB_TGL;
      end
      `GPB_OFS_INVAL: d.inp = 1'b1;
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction

  function automatic logic [W-1:0] merge(
      input logic [W-1:0] cur,
      input gpb_op_t op,
      input logic [31:0] data,
      input logic [3:0] be);
    logic [31:0] bm;
    logic [W-1:0] m;
    logic [W-1:0] r;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    m = W'(data & bm);
    case (op)
      GPB_CLR: r = cur & ~m;
      GPB_SET: r = cur | m;
      GPB_TGL: r = cur ^ m;
      default: r = (cur & ~W'(bm)) | m;
    endcase
    return r;
  endfunction

  function automatic logic blocked(
      input logic prot,
      input logic halt,
      input logic from_dbg);
    return prot & ~halt & ~from_dbg;
  endfunction

  function automatic logic [31:0] readback(
      input gpb_dec_t d,
      input logic [W-1:0] orient,
      input logic [W-1:0] drive,
      input logic [W-1:0] inval);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (d.inp) begin
      r = 32'(inval);
    end else if (d.drv) begin
      r = 32'(drive);
    end else if (d.hit) begin
      r = 32'(orient);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // access decode

  gpb_dec_t ld;
  gpb_dec_t pd;
  logic [3:0] lbe;
  logic lhit;
  logic lwr_ok;
  logic pacc;
  logic need_sync;
  logic [W-1:0] in_rd;

  assign ld = decode({lb_addr[7:2], 2'b00});
  assign pd = decode({paddr[7:2], 2'b00});
  assign lhit = lb_valid & (lb_addr[31:8] == LB_BASE[31:8]) & ld.hit;
  always_comb begin
    case (lb_size)
      2'h0: lbe = 4'h1 << lb_addr[1:0];
      2'h1: lbe = lb_addr[1] ? 4'hC : 4'h3;
      default: lbe = 4'hF;
    endcase
  end
  assign lwr_ok = lhit & lb_write & ~ld.inp
    & ~blocked(wprot[lb_addr[4:2]], dbg_halt, 1'b0);
  assign pacc = psel & penable;
  assign need_sync = pd.inp & ~pwrite & ~(&continuous_sync_group);
  // digital input disabled reads as zero
  assign in_rd = sif.in_val & pad_ie;

  assign sif.grp_en = continuous_sync_group | {G{s_r.st == GPB_SYNC}};

  ////////////////////////////////////////////////////////////////////////
  // state update

  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.periph_level = sif.pad_lvl & pmux_en;
    if (lhit && !lb_write) begin
      s_nxt.lb_rdata = readback(ld, s_r.orient, s_r.drive, in_rd);
    end
    if (lwr_ok) begin
      if (ld.drv) begin
        s_nxt.drive = merge(s_r.drive, ld.op, lb_wdata, lbe);
      end else begin
        s_nxt.orient = merge(s_r.orient, ld.op, lb_wdata, lbe);
      end
    end
    case (s_r.st)
      GPB_IDLE: begin
        if (pacc) begin
          s_nxt.st = need_sync ? GPB_SYNC : GPB_EXEC;
          s_nxt.cnt = 2'(`GPB_SYNC_CYC - 1);
        end
      end
      GPB_SYNC: begin
        s_nxt.cnt = s_r.cnt - 2'h1;
        if (s_r.cnt == 2'h0) begin
          s_nxt.st = GPB_EXEC;
        end
      end
      GPB_EXEC: begin
        if (!lb_valid) begin
          s_nxt.st = GPB_DONE;
          s_nxt.pready = 1'b1;
          s_nxt.prdata = pwrite ? 32'h0000_0000
            : readback(pd, s_r.orient, s_r.drive, in_rd);
          if (!pd.hit || (pwrite && pd.inp)) begin
            s_nxt.pslverr = 1'b1;
          end else if (pwrite) begin
            if (blocked(wprot[paddr[4:2]], dbg_halt, pdbg)) begin
              s_nxt.pslverr = 1'b1;
            end else if (pd.drv) begin
              s_nxt.drive = merge(s_r.drive, pd.op, pwdata, pstrb);
            end else begin
              s_nxt.orient = merge(s_r.orient, pd.op, pwdata, pstrb);
            end
          end
        end
      end
      GPB_DONE: s_nxt.st = GPB_IDLE;
      default: s_nxt.st = GPB_IDLE;
    endcase
    if (!nrst || port_off) begin
      s_nxt.orient = `GPB_RST_ORIENT;
      s_nxt.drive = `GPB_RST_DRIVE;
      s_nxt.st = GPB_IDLE;
      s_nxt.cnt = 2'h0;
      s_nxt.pready = 1'b0;
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      s_nxt.lb_rdata = 32'h0000_0000;
      s_nxt.periph_level = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // submodules and outputs

  gpb_sync #(.W(W), .G(G)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .port_off(port_off),
    .pad_in(pad_in),
    .sif(sif)
  );

  gpb_pad #(.W(W)) u_pad (
    .clk(clk),
    .nrst(nrst),
    .port_off(port_off),
    .orient(s_r.orient),
    .drive(s_r.drive),
    .in_en(in_en),
    .pull_en(pull_en),
    .pmux_en(pmux_en),
    .analog_sel(analog_sel),
    .periph_drive(periph_drive),
    .periph_oe(periph_oe),
    .pad_out(pad_out),
    .pad_oe_n(pad_oe_n),
    .pad_ie(pad_ie),
    .pad_pull(pad_pull)
  );

  assign lb_rdata = s_r.lb_rdata;
  assign pready = s_r.pready;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign periph_level = s_r.periph_level;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_lb_set: assert property (@(posedge clk) disable iff (!nrst)
    (lwr_ok && ld.drv && ld.op == GPB_SET && lbe == 4'hF && !port_off)
    |=> s_r.drive == ($past(s_r.drive) | W'($past(lb_wdata))))
    else $error("set mask did not raise the selected drive bits");
  a_lb_clr: assert property (@(posedge clk) disable iff (!nrst)
    (lwr_ok && !ld.drv && ld.op == GPB_CLR && lbe == 4'hF && !port_off)
    |=> s_r.orient == ($past(s_r.orient) & ~W'($past(lb_wdata))))
    else $error("clear mask disturbed unselected orient bits");
  a_prot_hold: assert property (@(posedge clk) disable iff (!nrst)
    (lhit && lb_write && wprot[lb_addr[4:2]] && !dbg_halt && !port_off
      && s_r.st != GPB_EXEC)
    |=> $stable(s_r.drive) && $stable(s_r.orient))
    else $error("protected register took a cpu write");
  a_dbg_lift: assert property (@(posedge clk) disable iff (!nrst)
    (lhit && lb_write && dbg_halt && ld.drv && ld.op == GPB_TGL
      && lbe == 4'hF && !port_off)
    |=> s_r.drive == ($past(s_r.drive) ^ W'($past(lb_wdata))))
    else $error("write during debug halt was blocked");
  a_lb_yield: assert property (@(posedge clk) disable iff (!nrst)
    (s_r.st == GPB_EXEC && lb_valid) |=> !pready)
    else $error("apb completed beside a local bus access");
  a_apb_go: assert property (@(posedge clk) disable iff (!nrst)
    (s_r.st == GPB_EXEC && !lb_valid && !port_off) |=> pready)
    else $error("apb held without local bus traffic");
  a_ondemand: assert property (@(posedge clk) disable iff (!nrst)
    (s_r.st == GPB_IDLE && pacc && need_sync && !port_off)
    |=> !pready [*3])
    else $error("on-demand input read answered too early");
  a_lb_read: assert property (@(posedge clk) disable iff (!nrst)
    (lhit && !lb_write && ld.inp && !port_off)
    |=> lb_rdata == 32'($past(in_rd)))
    else $error("local input read not answered at once");

  c_collide: cover property (@(posedge clk) disable iff (!nrst)
    s_r.st == GPB_EXEC && lb_valid ##1 pready);
  c_ondemand: cover property (@(posedge clk) disable iff (!nrst)
    s_r.st == GPB_SYNC ##2 s_r.st == GPB_EXEC);
  c_lb_flip: cover property (@(posedge clk) disable iff (!nrst)
    lwr_ok && ld.op == GPB_TGL);
endmodule // gpb_port
`default_nettype wire

// ---- bench/gpb_cpu_model.sv ----
// cpu side model: local bus and apb master of the pin port
`timescale 1ns/1ps
`default_nettype none
module gpb_cpu_model (
  input wire logic clk,
  output logic lb_valid,
  output logic lb_write,
  output logic [31:0] lb_addr,
  output logic [1:0] lb_size,
  output logic [31:0] lb_wdata,
  input wire logic [31:0] lb_rdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic pdbg,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  initial begin
    {lb_valid, lb_write, lb_size, psel, penable, pwrite, pstrb, pdbg} = '0;
    lb_addr = 32'h0000_0000;
    lb_wdata = 32'h0000_0000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one cycle transfer
  task automatic lb(input logic w, input logic [31:0] a, input logic [1:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    lb_valid <= 1'b1;
    lb_write <= w;
    lb_addr <= a;
    lb_size <= s;
    lb_wdata <= d;
    @(posedge clk);
    lb_valid <= 1'b0;
    lb_addr <= ~a;
    lb_wdata <= ~d;
    #1 r = lb_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // access held until ready is sampled, bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic dbg, output logic [31:0] r, output logic e,
                     output int n);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    pdbg <= dbg;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // gpb_cpu_model
`default_nettype wire

// ---- bench/tb_gpb_port.sv ----
// self-checking bench of the pin port
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"
`define CHK(a, e) begin \
    checks++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); \
    end \
  end
module tb_gpb_port;
  logic clk = 1'b0;
  logic nrst, port_off, dbg_halt, pdbg, psel, penable, pwrite, pready, pslverr;
  logic lb_valid, lb_write;
  logic [1:0] lb_size;
  logic [3:0] pstrb, continuous_sync_group;
  logic [7:0] paddr, wprot;
  logic [31:0] lb_addr, lb_wdata, lb_rdata, pwdata, prdata, rd, prd;
  logic [31:0] in_en, pull_en, pmux_en, analog_sel, periph_drive, periph_oe;
  logic [31:0] periph_level, pad_in, pad_out, pad_oe_n, pad_ie, pad_pull;
  logic perr;
  int n, n0;
  int checks = 0;
  int miscompares = 0;

  always #50 clk = ~clk;

  gpb_port i_dut (.clk, .nrst, .port_off, .dbg_halt, .lb_valid, .lb_write, .lb_addr,
    .lb_size, .lb_wdata, .lb_rdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pdbg, .pready, .prdata, .pslverr, .wprot, .continuous_sync_group, .in_en,
    .pull_en, .pmux_en, .analog_sel, .periph_drive, .periph_oe, .periph_level,
    .pad_in, .pad_out, .pad_oe_n, .pad_ie, .pad_pull);

  gpb_cpu_model i_cpu (.clk, .lb_valid, .lb_write, .lb_addr, .lb_size, .lb_wdata,
    .lb_rdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pdbg, .pready,
    .prdata, .pslverr);

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic lw(input logic [7:0] o, input logic [1:0] s, input logic [31:0] d);
    i_cpu.lb(1'b1, `GPB_LB_BASE + 32'(o), s, d, rd);
  endtask

  task automatic lr(input logic [7:0] o);
    i_cpu.lb(1'b0, `GPB_LB_BASE + 32'(o), 2'h2, 32'h0000_0000, rd);
  endtask

  task automatic ap(input logic w, input logic [7:0] o, input logic [31:0] d,
                    input logic dbg);
    i_cpu.apb(w, o, d, dbg, prd, perr, n);
    if (n >= 20) begin
      miscompares++;
      $display("wrong value at %0t: apb access never ended", $time);
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // masked writes of every size, out of range ignored, both buses agree
  task automatic t_ops();
    lw(8'h10, 2'h2, 32'h0000_00F0);
    lw(8'h19, 2'h0, 32'hFFFF_FFFF);
    lw(8'h1E, 2'h1, 32'hFFFF_FFFF);
    lw(8'h14, 2'h2, 32'h0000_0F00);
    lw(8'h08, 2'h2, 32'h0000_FFFF);
    lw(8'h04, 2'h2, 32'h0000_000F);
    lw(8'h0C, 2'h2, 32'h0001_0000);
    i_cpu.lb(1'b1, 32'h6000_0118, 2'h2, 32'hFFFF_FFFF, rd);
    lr(8'h10);
    `CHK(rd, 32'hFFFF_F0F0)
    lr(8'h00);
    `CHK(rd, 32'h0001_FFF0)
    ap(1'b0, 8'h00, 32'h0000_0000, 1'b0);
    `CHK(prd, 32'h0001_FFF0)
    n0 = n;
    `CHK(pad_oe_n, 32'hFFFE_000F)
    `CHK(pad_out, 32'hFFFF_F0F0)
  endtask

  // sampled group live, others stale, on-demand read two cycles slower
  task automatic t_in();
    lr(8'h20);
    `CHK(rd, 32'h0000_005A)
    ap(1'b0, 8'h20, 32'h0000_0000, 1'b0);
    `CHK(prd, 32'hA5C3_3C5A)
    `CHK(n, n0 + 2)
    @(posedge clk);
    pad_in <= 32'h1234_5678;
    repeat (4) @(posedge clk);
    lr(8'h20);
    `CHK(rd, 32'hA5C3_3C78)
  endtask

  // local writes during an apb access stretch it
  task automatic t_coll();
    fork
      ap(1'b1, 8'h18, 32'h0000_0001, 1'b0);
      begin
        repeat (2) @(posedge clk);
        lw(8'h18, 2'h2, 32'h0000_0100);
        lw(8'h18, 2'h2, 32'h0000_0200);
      end
    join
    `CHK(n > n0, 1'b1)
    `CHK(perr, 1'b0)
    lr(8'h10);
    `CHK(rd, 32'hFFFF_F3F1)
  endtask

  // protection on drive set and flip, debugger bypasses it on set, debug halt on flip
  task automatic t_prot();
    @(posedge clk);
    wprot <= 8'hC0;
    lw(8'h18, 2'h2, 32'h0000_0002);
    ap(1'b1, 8'h18, 32'h0000_0004, 1'b0);
    `CHK(perr, 1'b1)
    ap(1'b1, 8'h18, 32'h0000_0008, 1'b1);
    `CHK(perr, 1'b0)
    @(posedge clk);
    dbg_halt <= 1'b1;
    lw(8'h1C, 2'h2, 32'h0000_0400);
    lr(8'h10);
    `CHK(rd, 32'hFFFF_F7F9)
    @(posedge clk);
    dbg_halt <= 1'b0;
    wprot <= 8'h00;
  endtask

  // analog pin loses digital pad, muxed pin follows the peripheral
  task automatic t_pad();
    @(posedge clk);
    analog_sel <= 32'h0000_0010;
    pmux_en <= 32'h0010_0000;
    periph_oe <= 32'h0010_0000;
    periph_drive <= 32'h0000_0000;
    continuous_sync_group <= 4'h0;
    pad_in <= 32'h0010_0000;
    repeat (4) @(posedge clk);
    #1;
    `CHK({pad_oe_n[4], pad_ie[4], pad_pull[4]}, 3'h4)
    `CHK({pad_oe_n[20], pad_out[20]}, 2'h0)
    `CHK(periph_level, 32'h0010_0000)
    lr(8'h20);
    `CHK(rd, 32'hA5C3_3C68)
  endtask

  // power-down holds pads and wipes registers
  task automatic t_off();
    @(posedge clk);
    port_off <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(pad_out, 32'hFFEF_F7F9)
    @(posedge clk);
    port_off <= 1'b0;
    lr(8'h10);
    `CHK(rd, `GPB_RST_DRIVE)
    lr(8'h00);
    `CHK(rd, `GPB_RST_ORIENT)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, port_off, dbg_halt} = 3'h0;
    wprot = 8'h00;
    continuous_sync_group = 4'h1;
    in_en = 32'hFFFF_FFFF;
    pull_en = 32'hFFFF_FFFF;
    {pmux_en, analog_sel, periph_drive, periph_oe} = '0;
    pad_in = 32'hA5C3_3C5A;
    repeat (3) @(posedge clk);
    #1;
    `CHK({pad_oe_n, pad_ie, pad_pull}, {32'hFFFF_FFFF, 64'h0})
    repeat (17) @(posedge clk);
    nrst <= 1'b1;
    t_ops();
    t_in();
    t_coll();
    t_prot();
    t_pad();
    t_off();
    summarize();
  end
endmodule // tb_gpb_port
`default_nettype wire
